// File: ssrp_top.v
// SPI slave register port with write-data FIFO and register file
`include "ssrp_map.vh"
`default_nettype none

// ==========================================================
// Small synchronous FIFO for write data
module ssrp_fifo #(
  parameter WIDTH = 14,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             ref_clk_i,
  input  wire             rst_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr_reg;
  reg [AW:0]      rd_ptr_reg;
  wire            full;
  wire            empty;

  // Extra pointer bit tells full from empty
  assign empty       = (wr_ptr_reg == rd_ptr_reg);
  assign full        = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) &&
                       (wr_ptr_reg[AW] != rd_ptr_reg[AW]);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem[rd_ptr_reg[AW-1:0]];

  // Storage has no reset; pointers define contents
  always @(posedge ref_clk_i) begin
    if (in_valid_i && !full)
      mem[wr_ptr_reg[AW-1:0]] <= in_data_i;
  end

  // Pointer update
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
    end else begin
      if (in_valid_i && !full)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (out_ready_i && !empty)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule // ssrp_fifo

// ==========================================================
// Port top: pin sampling, shifter, register file
module ssrp_top #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW    = 3
) (
  input  wire       ref_clk_i,
  input  wire       rst_i,
  input  wire       cs_n_i,
  input  wire       sclk_i,
  input  wire       sdi_i,
  output reg        sdio_o,
  output reg        sdio_oe_n_o,
  output reg        sdo_o,
  output reg        sdo_oe_n_o,
  output reg        two_wire_sel_o,
  output reg        wire3_mode_o,
  output reg        xfer_active_o
);
  localparam ST_IDLE = 3'b001;
  localparam ST_CMD  = 3'b010;
  localparam ST_DATA = 3'b100;

  reg [1:0] cs_sync_reg;
  reg [2:0] sclk_sync_reg;
  reg [1:0] sdi_sync_reg;
  reg [2:0] state_reg;
  reg [2:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [5:0] addr_reg;
  reg       read_reg;
  reg       mb_reg;
  reg [7:0] fmt_cfg_reg;
  reg       out_bit_reg;
  reg [7:0] regs [0:63];
  reg [5:0] rd_addr_reg;
  wire      cs_n_s;
  wire      sclk_rise;
  wire      sclk_fall;
  wire      sdi_s;
  wire [7:0] shifted;
  wire       wr_valid;
  wire       wr_ready;
  wire [13:0] wr_data;
  wire       q_valid;
  wire [13:0] q_data;

  // Second stage onward only; stage 0 feeds stage 1 alone
  assign cs_n_s    = cs_sync_reg[1];
  assign sdi_s     = sdi_sync_reg[1];
  assign sclk_rise = sclk_sync_reg[1] && !sclk_sync_reg[2];
  assign sclk_fall = !sclk_sync_reg[1] && sclk_sync_reg[2];
  assign shifted   = {shift_reg[6:0], sdi_s};

  // Two-flop synchronisers for cs and sdi, three flops for sclk
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cs_sync_reg   <= 2'h3;
      sclk_sync_reg <= 3'h7;
      sdi_sync_reg  <= 2'h3;
    end else begin
      cs_sync_reg   <= {cs_sync_reg[0], cs_n_i};
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_i};
      sdi_sync_reg  <= {sdi_sync_reg[0], sdi_i};
    end
  end

  // Completed write bytes queue here so register stores decouple from the shifter
  assign wr_valid = (state_reg == ST_DATA) && !read_reg && sclk_rise &&
                    (bit_cnt_reg == 3'h7) && !cs_n_s && wr_ready;
  assign wr_data  = {addr_reg, shifted};

  ssrp_fifo #(.WIDTH(14), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (wr_valid),
    .in_ready_o  (wr_ready),
    .in_data_i   (wr_data),
    .out_valid_o (q_valid),
    .out_ready_i (1'b1),
    .out_data_o  (q_data)
  );

  // Frame state machine and shifter
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg   <= ST_IDLE;
      bit_cnt_reg <= 3'h0;
      shift_reg   <= 8'h00;
      addr_reg    <= 6'h00;
      read_reg    <= 1'b0;
      mb_reg      <= 1'b0;
    end else if (cs_n_s) begin
      state_reg   <= ST_IDLE;
      bit_cnt_reg <= 3'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          state_reg   <= ST_CMD;
          bit_cnt_reg <= 3'h0;
        end
        ST_CMD: begin
          if (sclk_rise) begin
            shift_reg   <= shifted;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7) begin
              read_reg  <= shifted[`SSRP_CMD_READ_BIT];
              mb_reg    <= shifted[`SSRP_CMD_MB_BIT];
              addr_reg  <= shifted[5:0];
              state_reg <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (sclk_rise) begin
            shift_reg   <= shifted;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7) begin
              if (mb_reg)
                addr_reg <= addr_reg + 6'h01;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Register file store, drained from the FIFO
  always @(posedge ref_clk_i) begin
    if (q_valid)
      regs[q_data[13:8]] <= q_data[7:0];
  end

  // Format register kept in flops so the whole byte has a reset value
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fmt_cfg_reg  <= `SSRP_FMT_CFG_RESET;
      wire3_mode_o <= 1'b0;
    end else if (q_valid && q_data[13:8] == `SSRP_FMT_CFG_ADDR) begin
      fmt_cfg_reg  <= q_data[7:0];
      wire3_mode_o <= q_data[`SSRP_FMT_WIRE3_BIT];
    end
  end

  // Read path: load byte at address, shift out on falling edges
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_bit_reg <= 1'b1;
      rd_addr_reg <= 6'h00;
    end else begin
      rd_addr_reg <= addr_reg;
      if (sclk_fall && state_reg == ST_DATA && read_reg)
        out_bit_reg <= (rd_addr_reg == `SSRP_FMT_CFG_ADDR) ?
                       fmt_byte(bit_cnt_reg) : reg_bit(bit_cnt_reg);
      else if (state_reg != ST_DATA)
        out_bit_reg <= 1'b1;
    end
  end

  // Pick MSB-first bit of the addressed register
  function reg_bit;
    input [2:0] idx;
    reg [7:0] b;
    begin
      b = regs[rd_addr_reg];
      reg_bit = b[3'h7 - idx];
    end
  endfunction

  function fmt_byte;
    input [2:0] idx;
    reg [7:0] b;
    begin
      b = fmt_cfg_reg;
      fmt_byte = b[3'h7 - idx];
    end
  endfunction

  // Pin drivers; enables are active low
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sdo_o          <= 1'b1;
      sdo_oe_n_o     <= 1'b1;
      sdio_o         <= 1'b1;
      sdio_oe_n_o    <= 1'b1;
      two_wire_sel_o <= 1'b1;
      xfer_active_o  <= 1'b0;
    end else begin
      // select high means two-wire may listen
      two_wire_sel_o <= cs_n_s;
      xfer_active_o  <= !cs_n_s;
      sdo_o          <= out_bit_reg;
      sdio_o         <= out_bit_reg;
      // drive only reading; separate output in four wire
      sdo_oe_n_o     <= !(!cs_n_s && state_reg == ST_DATA && read_reg && !wire3_mode_o);
      sdio_oe_n_o    <= !(!cs_n_s && state_reg == ST_DATA && read_reg && wire3_mode_o);
    end
  end
endmodule // ssrp_top
`default_nettype wire

// File: ssrp_map.vh
// Constants for the serial register port
`ifndef SSRP_MAP_VH
`define SSRP_MAP_VH
// Register offsets (6-bit register address space)
`define SSRP_FMT_CFG_ADDR     6'h31
// Format configuration fields
`define SSRP_FMT_WIRE3_BIT    6
`define SSRP_FMT_CFG_RESET    8'h00
// First byte layout
`define SSRP_CMD_READ_BIT     7
`define SSRP_CMD_MB_BIT       6
// Timing, in ns, and cycle counts at the 100 MHz clock
`define SSRP_CLK_PERIOD_NS    10
`define SSRP_CS_DIS_MIN_NS    150
`define SSRP_CS_DIS_CYC       ((`SSRP_CS_DIS_MIN_NS + `SSRP_CLK_PERIOD_NS - 1) / `SSRP_CLK_PERIOD_NS)
`endif

// File: ssrp_chk_sva.sv
// Checker of the serial register port pins
`default_nettype none
// ====
// Pin checker
module ssrp_chk (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic sdi_i,
  input wire logic sdio_o,
  input wire logic sdio_oe_n_o,
  input wire logic sdo_o,
  input wire logic sdo_oe_n_o,
  input wire logic two_wire_sel_o,
  input wire logic wire3_mode_o,
  input wire logic xfer_active_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pin syncs lag about three cycles, so windows are five long
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_sel_idle: assert property (cs_n_i [*5] |-> two_wire_sel_o)
    else $error("no two-wire select");
  a_frame_on: assert property (
    (!cs_n_i) [*5] |-> xfer_active_o && !two_wire_sel_o)
    else $error("frame not seen");
  a_idle_off: assert property (cs_n_i [*5] |-> sdo_oe_n_o && sdio_oe_n_o)
    else $error("drive while idle");
  a_sdo_w3_off: assert property (wire3_mode_o |-> sdo_oe_n_o)
    else $error("sdo on in 3-wire");
  a_sdio_w4_off: assert property (!wire3_mode_o |-> sdio_oe_n_o)
    else $error("sdio on in 4-wire");
  // Output may move only a few cycles after a pin fall, never after a rise
  a_sdo_fall: assert property (
    !cs_n_i && !sdo_oe_n_o && $changed(sdo_o) |-> !$past(sclk_i,3) || !$past(sclk_i,4))
    else $error("sdo moved off fall");
  a_sdio_fall: assert property (
    !cs_n_i && !sdio_oe_n_o && $changed(sdio_o) |-> !$past(sclk_i,3) || !$past(sclk_i,4))
    else $error("sdio moved off fall");
  a_mode_frame: assert property ($changed(wire3_mode_o) |-> xfer_active_o)
    else $error("mode moved outside frame");
endmodule // ssrp_chk
bind ssrp_top ssrp_chk u_chk (
  .ref_clk_i      (ref_clk_i),
  .rst_i          (rst_i),
  .cs_n_i         (cs_n_i),
  .sclk_i         (sclk_i),
  .sdi_i          (sdi_i),
  .sdio_o         (sdio_o),
  .sdio_oe_n_o    (sdio_oe_n_o),
  .sdo_o          (sdo_o),
  .sdo_oe_n_o     (sdo_oe_n_o),
  .two_wire_sel_o (two_wire_sel_o),
  .wire3_mode_o   (wire3_mode_o),
  .xfer_active_o  (xfer_active_o)
);
`default_nettype wire

// File: ssrp_spi_master.sv
// Behavioural SPI master facing the serial register port
`default_nettype none
// ====
// Master model
module ssrp_spi_master (
  output logic      cs_n_o,
  output logic      sclk_o,
  output wire logic sdi_o,
  input wire logic  sdo_i,
  input wire logic  sdio_i,
  input wire logic  sdio_oe_n_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] wd[4];
  logic [7:0] rd[4];
  logic dout = 1;
  logic rel = 0;
  logic wr = 0;
  // clock idles high, select high from the start
  initial begin
    cs_n_o = 1;
    sclk_o = 1;
  end
  // Released line shows the device, else the inverse of the last level
  assign sdi_o = !rel ? dout : (!sdio_oe_n_i ? sdio_i : ~dout);
  // framed 80 ns clock, 200 ns gap
  // Low 50 ns, high 30 ns keeps every pin move 1 ns past a clock edge
  task automatic xfer(input logic [7:0] cmd, input int n, input logic w3);
    cs_n_o = 0;
    wr = !cmd[7];
    #20;
    for (int b = 0; b <= n; b++) begin
      for (int i = 7; i >= 0; i--) begin
        // MSB first, changed on the fall
        sclk_o = 0;
        if (b == 0) dout = cmd[i];
        else if (wr) dout = wd[b-1][i];
        else rel = w3;
        #50;
        // data back taken in reads only
        if (b > 0 && !wr) rd[b-1][i] = w3 ? sdi_o : sdo_i;
        sclk_o = 1;
        #30;
      end
    end
    #100;
    cs_n_o = 1;
    // data line held high while deselected
    rel = 0;
    dout = 1;
    wr = 0;
    #200;
  endtask
endmodule // ssrp_spi_master
`default_nettype wire

// File: test_spi_slave_register_port.sv
// Self-checking bench of the serial register port
`default_nettype none
// ====
// Bench top
module test_spi_slave_register_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0;
  logic rst = 1;
  logic wdrv = 0;
  wire  cs_n, sclk, sdi, sdo, sdo_oe_n, sdio, sdio_oe_n, sel, w3, act;
  int   n_mismatch = 0;
  int   cmp_count = 0;
  ssrp_top dut (.ref_clk_i(clk), .rst_i(rst), .cs_n_i(cs_n), .sclk_i(sclk),
    .sdi_i(sdi), .sdio_o(sdio), .sdio_oe_n_o(sdio_oe_n), .sdo_o(sdo),
    .sdo_oe_n_o(sdo_oe_n), .two_wire_sel_o(sel), .wire3_mode_o(w3),
    .xfer_active_o(act));
  // Undriven sdo shows the inverse so a missing drive is seen
  ssrp_spi_master m (.cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi),
    .sdo_i(sdo_oe_n ? ~sdo : sdo), .sdio_i(sdio), .sdio_oe_n_i(sdio_oe_n));
  initial forever #5 clk = ~clk;
  // Flag any drive of a data output during a write frame
  always @(posedge clk) if (m.wr && !(sdo_oe_n && sdio_oe_n)) wdrv <= 1;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic t_reset;
    chk({3'h0, w3, sel, act, sdo_oe_n, sdio_oe_n}, 8'h0b);
    m.xfer(8'hb1, 1, 0);
    chk(m.rd[0], 8'h00);
  endtask
  task automatic t_multi;
    m.wd = '{8'h11, 8'h22, 8'h33, 8'h00};
    m.xfer(8'h6e, 3, 0);
    m.wd[0] = 8'h44;
    m.wd[1] = 8'h55;
    m.xfer(8'h2e, 2, 0);
    m.xfer(8'hee, 3, 0);
    chk(m.rd[0], 8'h55);
    chk(m.rd[1], 8'h22);
    chk(m.rd[2], 8'h33);
    chk({7'h0, sel}, 8'h01);
    chk({7'h0, act}, 8'h00);
  endtask
  task automatic t_wire3;
    m.wd[0] = 8'h40;
    m.xfer(8'h31, 1, 0);
    chk({7'h0, w3}, 8'h01);
    m.xfer(8'hef, 2, 1);
    chk(m.rd[0], 8'h22);
    chk(m.rd[1], 8'h33);
    m.xfer(8'hb1, 1, 1);
    chk(m.rd[0], 8'h40);
    m.wd[0] = 8'h00;
    m.xfer(8'h31, 1, 1);
    chk({7'h0, w3}, 8'h00);
    chk({7'h0, wdrv}, 8'h00);
  endtask
  task automatic finish_test;
    $display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1 rst = 0;
    t_reset();
    t_multi();
    t_wire3();
    finish_test();
  end
  // Tests need about 17 us; cut a hang well past that
  initial begin
    #200000;
    n_mismatch++;
    finish_test();
  end
endmodule // test_spi_slave_register_port
`default_nettype wire
